// *** design/ucpc_port_classifier.sv ***
`timescale 1ns/1ps
// What this block does
// - start classifying on supply rise above undervoltage, and on software restart
// - apply limits: cdp/dcp 1500, divided ports 500/1000/1800 ma
// - sdp limit is 100 ma with select pin low, 500 ma high
// - class shows in read-only result bits 5..3 with fixed codes
// - dp and dm both open: treat as sdp, set timeout flag
// - dp or dm above 3.3 v: set line error code, suspend
// - error suspend holds until restart or manual limit select with neither line still hot, then leaves
// - divided ports: mid/mid port1, mid/high port2, high/mid port3
// - after classification release dp and dm, all sources and sinks off
// - load switch gate held high (off) while classifying
// - remain suspended, no input current, while classifying
module ucpc_port_classifier
  import ucpc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES  = SETTLE_CYC,
  parameter int unsigned DCD_TMO_CYCLES = DCD_TIMEOUT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire ucpc_comp_t  comp_in,
  input  wire logic        restart_port_detect,
  input  wire logic        manual_limit_select,
  output logic [7:0]       usb_port_class_result,
  output logic             contact_detect_timeout_flag,
  output ucpc_limit_t      input_limit,
  output logic             suspend,
  output logic             load_switch_gate_n,
  output ucpc_line_t       line_ctl,
  output logic             detect_busy
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DIV     = 3'b001,
    ST_DCD     = 3'b010,
    ST_PRIMARY = 3'b011,
    ST_SECOND  = 3'b100,
    ST_DONE    = 3'b101,
    ST_ERROR   = 3'b110
  } ucpc_state_t;

  ucpc_comp_t   comp_s;
  ucpc_state_t  state_r;
  ucpc_class_t  class_r;
  logic [TMR_W-1:0] tmr_r;
  logic         supply_d_r;
  logic         tmo_r;
  logic         manual_d_r;
  logic         start;
  logic         settled;
  logic         dcd_tmo;
  logic         line_err;
  ucpc_limit_t  limit_nxt;

  ucpc_sync #(
    .W (COMP_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (comp_in),
    .q       (comp_s)
  );

  // limit for each class
  function automatic ucpc_limit_t class_limit(input ucpc_class_t c, input logic pin);
    unique case (c)
      CLS_SDP:                class_limit = pin ? LIM_500MA : LIM_100MA;
      CLS_CDP, CLS_DCP:       class_limit = LIM_1500MA;
      CLS_DIV1:               class_limit = LIM_500MA;
      CLS_DIV2:               class_limit = LIM_1000MA;
      CLS_DIV3:               class_limit = LIM_1800MA;
      CLS_DP_ERR, CLS_DM_ERR: class_limit = LIM_SUSPEND;
    endcase
  endfunction : class_limit

  // start on supply rising edge or restart write
  assign start   = (comp_s.supply_ok && !supply_d_r) || restart_port_detect;
  assign settled = (tmr_r >= TMR_W'(SETTLE_CYCLES));
  assign dcd_tmo = (tmr_r >= TMR_W'(DCD_TMO_CYCLES));
  assign line_err = comp_s.dp_ovp || comp_s.dm_ovp;

  // edge history
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      supply_d_r <= 1'b0;
      manual_d_r <= 1'b0;
    end else begin
      supply_d_r <= comp_s.supply_ok;
      manual_d_r <= manual_limit_select;
    end
  end

  // step timer, cleared entering each timed step, held at zero in idle, done and error
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tmr_r <= '0;
    end else if (start || (state_r == ST_IDLE) || (state_r == ST_DONE) || (state_r == ST_ERROR)) begin
      tmr_r <= '0;
    end else if (state_r == ST_DIV && settled) begin
      tmr_r <= '0;
    end else if (state_r == ST_DCD && ((settled && !comp_s.dp_dat) || dcd_tmo)) begin
      tmr_r <= '0;
    end else if (state_r == ST_PRIMARY && settled) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  // detection sequence
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      class_r <= CLS_SDP;
      tmo_r   <= 1'b0;
    end else if (!comp_s.supply_ok) begin
      state_r <= ST_IDLE;
    end else if (start) begin
      state_r <= ST_DIV;
      tmo_r   <= 1'b0;
    end else if (line_err) begin
      // a hot line holds error and keeps the code on the line now hot
      state_r <= ST_ERROR;
      class_r <= comp_s.dp_ovp ? CLS_DP_ERR : CLS_DM_ERR;
      tmo_r   <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_DIV: begin
          if (settled) begin
            // divided supply levels are judged before the data line tests
            if (comp_s.dp_div_mid && comp_s.dm_div_mid) begin
              class_r <= CLS_DIV1;
              state_r <= ST_DONE;
            end else if (comp_s.dp_div_mid && comp_s.dm_div_high) begin
              class_r <= CLS_DIV2;
              state_r <= ST_DONE;
            end else if (comp_s.dp_div_high && comp_s.dm_div_mid) begin
              class_r <= CLS_DIV3;
              state_r <= ST_DONE;
            end else begin
              state_r <= ST_DCD;
            end
          end
        end
        ST_DCD: begin
          // contact judged only once the source and synchroniser have settled
          if (settled && !comp_s.dp_dat) begin
            state_r <= ST_PRIMARY;
          end else if (dcd_tmo) begin
            class_r <= CLS_SDP;
            tmo_r   <= 1'b1;
            state_r                     <= ST_DONE;
          end
        end
        ST_PRIMARY: begin
          if (settled) begin
            if (comp_s.dm_dat) begin
              state_r <= ST_SECOND;
            end else begin
              class_r <= CLS_SDP;
              state_r <= ST_DONE;
            end
          end
        end
        ST_SECOND: begin
          if (settled) begin
            class_r <= comp_s.dp_dat ? CLS_DCP : CLS_CDP;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_DONE;
        ST_ERROR: begin
          // manual limit selection leaves error suspend
          if (manual_limit_select && !manual_d_r) begin
            state_r <= ST_DONE;
          end
        end
      endcase
    end
  end

  assign detect_busy = (state_r == ST_DIV) || (state_r == ST_DCD) ||
                       (state_r == ST_PRIMARY) || (state_r == ST_SECOND);

  // limit chosen from class unless idle, busy or in error
  always_comb begin
    if (detect_busy || state_r == ST_ERROR || state_r == ST_IDLE) begin
      limit_nxt = LIM_SUSPEND;
    end else begin
      limit_nxt = class_limit(class_r, comp_s.limit_pin);
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      input_limit                 <= LIM_SUSPEND;
      contact_detect_timeout_flag <= 1'b0;
      suspend                     <= 1'b1;
      load_switch_gate_n    <= 1'b1;
      usb_port_class_result <= RESULT_RESET;
    end else begin
      input_limit                 <= limit_nxt;
      // manual exit from error leaves suspend while software owns the limit
      suspend                     <= (state_r != ST_DONE);
      contact_detect_timeout_flag <= tmo_r;
      load_switch_gate_n    <= detect_busy || (state_r == ST_IDLE);
      usb_port_class_result <= RESULT_RESET;
      usb_port_class_result[CLASS_MSB:CLASS_LSB] <= class_r;
    end
  end

  // line stimulus per step, all off once classified
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      line_ctl <= LINES_OFF;
    end else begin
      line_ctl <= LINES_OFF;
      unique case (state_r)
        ST_DCD: line_ctl.dcd_src_en <= 1'b1;
        ST_PRIMARY: begin
          line_ctl.dp_src_en  <= 1'b1;
          line_ctl.dm_sink_en <= 1'b1;
        end
        ST_SECOND: begin
          line_ctl.dm_src_en  <= 1'b1;
          line_ctl.dp_sink_en <= 1'b1;
        end
        ST_IDLE, ST_DIV, ST_DONE, ST_ERROR: line_ctl <= LINES_OFF;
      endcase
    end
  end
endmodule : ucpc_port_classifier

// *** design/ucpc_sync.sv ***
`timescale 1ns/1ps
// two flop synchroniser for a vector of independent levels
module ucpc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ucpc_sync

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// table of sources with queued expectations
module testbench
  import ucpc_pkg::*;
;
  logic        clk_sys, nrst, restart_port_detect, manual_limit_select, supply_on, pin_hi;
  logic [3:0]  kind;
  ucpc_comp_t  comp_in;
  ucpc_line_t  line_ctl;
  ucpc_limit_t input_limit;
  logic [7:0]  usb_port_class_result;
  logic        contact_detect_timeout_flag, suspend, load_switch_gate_n, detect_busy;
  logic [12:0] act;
  logic [12:0] exp_q[$];
  logic [3:0]  kinds[10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h3, 4'h7, 4'h0};
  logic [31:0] rng;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  assign act = {usb_port_class_result, input_limit, contact_detect_timeout_flag, suspend};
  ucpc_port_classifier #(.SETTLE_CYCLES(20), .DCD_TMO_CYCLES(50)) ucpc_port_classifier_inst (
    .clk_sys(clk_sys), .nrst(nrst), .comp_in(comp_in), .restart_port_detect(restart_port_detect),
    .manual_limit_select(manual_limit_select), .usb_port_class_result(usb_port_class_result),
    .contact_detect_timeout_flag(contact_detect_timeout_flag), .input_limit(input_limit),
    .suspend(suspend), .load_switch_gate_n(load_switch_gate_n), .line_ctl(line_ctl), .detect_busy(detect_busy));
  ucpc_port_model ucpc_port_model_inst (
    .supply_on(supply_on), .pin_hi(pin_hi), .kind(kind), .line_ctl(line_ctl), .comp(comp_in));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // expected {result, limit, flag, suspend} per source kind
  function automatic logic [12:0] exp_of(input logic [3:0] k, input logic p);
    ucpc_limit_t l;
    case (k)
      4'h1, 4'h2: l = LIM_1500MA;
      4'h4: l = LIM_500MA;
      4'h5: l = LIM_1000MA;
      4'h6: l = LIM_1800MA;
      4'h3, 4'h7: l = LIM_SUSPEND;
      default: l = p ? LIM_500MA : LIM_100MA;
    endcase
    return {2'b00, k[2:0], 3'b000, l, k == 4'h8, l == LIM_SUSPEND};
  endfunction : exp_of
  task automatic chk(input logic [12:0] e, input logic [12:0] a);
    checks_done++;
    if (a !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      tally_and_finish();
    end
  end
  // each finished detection is compared with the oldest note
  always @(negedge detect_busy) begin
    if (nrst === 1'b1) begin
      @(posedge clk_sys);
      #2;
      if (exp_q.size() == 0) chk(13'h1fff, act);
      else chk(exp_q.pop_front(), act);
    end
  end
  initial begin
    nrst = 1'b0;
    restart_port_detect = 1'b0;
    manual_limit_select = 1'b0;
    supply_on = 1'b0;
    pin_hi = 1'b0;
    kind = 4'h0;
    rng = 32'hec81;
    repeat (16) @(posedge clk_sys);
    #2 nrst = 1'b1;
    foreach (kinds[i]) begin
      rng = xs(rng);
      @(posedge clk_sys);
      #2 kind = kinds[i];
      pin_hi = rng[0];
      exp_q.push_back(exp_of(kinds[i], rng[0]));
      repeat (4) @(posedge clk_sys);
      #2 if (i == 0) supply_on = 1'b1; else restart_port_detect = 1'b1;
      @(posedge clk_sys);
      #2 restart_port_detect = 1'b0;
      repeat (4) @(posedge clk_sys);
      do begin
        @(posedge clk_sys);
        #2;
      end while (detect_busy === 1'b1);
      repeat (4) @(posedge clk_sys);
      // manual select leaves error suspend but keeps the class
      if (i == 8) begin
        #2 kind = 4'h0;
        repeat (4) @(posedge clk_sys);
        #2 manual_limit_select = 1'b1;
        repeat (4) @(posedge clk_sys);
        // class kept, suspend left
        #2 chk(exp_of(4'h7, 1'b0) & 13'h1ffe, act);
        manual_limit_select = 1'b0;
      end
    end
    tally_and_finish();
  end
endmodule : testbench
bind ucpc_port_classifier ucpc_checker #(.SETTLE_CYCLES(SETTLE_CYCLES), .DCD_TMO_CYCLES(DCD_TMO_CYCLES))
  ucpc_checker_inst (.clk_sys(clk_sys), .nrst(nrst), .comp_in(comp_in), .restart_port_detect(restart_port_detect),
  .manual_limit_select(manual_limit_select), .usb_port_class_result(usb_port_class_result),
  .contact_detect_timeout_flag(contact_detect_timeout_flag), .input_limit(input_limit),
  .suspend(suspend), .load_switch_gate_n(load_switch_gate_n), .line_ctl(line_ctl), .detect_busy(detect_busy));

// *** dv/ucpc_checker_asserts.sv ***
`timescale 1ns/1ps
// port level checks of the classifier
module ucpc_checker
  import ucpc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES  = SETTLE_CYC,
  parameter int unsigned DCD_TMO_CYCLES = DCD_TIMEOUT_CYC
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire ucpc_comp_t  comp_in,
  input wire logic        restart_port_detect,
  input wire logic        manual_limit_select,
  input wire logic [7:0]  usb_port_class_result,
  input wire logic        contact_detect_timeout_flag,
  input wire ucpc_limit_t input_limit,
  input wire logic        suspend,
  input wire logic        load_switch_gate_n,
  input wire ucpc_line_t  line_ctl,
  input wire logic        detect_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [2:0] cls;
  assign cls = usb_port_class_result[5:3];
  // limit expected for charging and divided classes
  function automatic ucpc_limit_t lim_of(input logic [2:0] c);
    case (c)
      CLS_CDP, CLS_DCP: lim_of = LIM_1500MA;
      CLS_DIV1: lim_of = LIM_500MA;
      CLS_DIV2: lim_of = LIM_1000MA;
      CLS_DIV3: lim_of = LIM_1800MA;
      default: lim_of = LIM_SUSPEND;
    endcase
  endfunction : lim_of
  // steps: supply seen stable then restart; detection ends with power on
  sequence s_armed;
    comp_in.supply_ok [*3] ##0 restart_port_detect;
  endsequence
  sequence s_done;
    $fell(detect_busy) ##1 !suspend;
  endsequence
  a_restart_starts_detect: assert property (s_armed |=> detect_busy)
    else $error("restart did not start detection");
  a_charger_limit_set: assert property (s_done ##0 cls != CLS_SDP |-> input_limit == lim_of(cls))
    else $error("limit does not match class");
  // the limit seen now was chosen from the pin level three samples back
  a_sdp_limit_pin: assert property (s_done ##0 cls == CLS_SDP |->
    input_limit == ($past(comp_in.limit_pin, 3) ? LIM_500MA : LIM_100MA))
    else $error("sdp limit does not follow pin");
  a_timeout_means_sdp: assert property (contact_detect_timeout_flag |-> cls == CLS_SDP)
    else $error("timeout flag without sdp class");
  a_dp_hot_error: assert property (comp_in.dp_ovp [*3] ##0 !restart_port_detect
    |-> ##[1:2] (suspend && cls == CLS_DP_ERR))
    else $error("dp over voltage not flagged");
  a_dm_hot_error: assert property ((comp_in.dm_ovp && !comp_in.dp_ovp) [*3] ##0 !restart_port_detect
    |-> ##[1:2] (suspend && cls == CLS_DM_ERR))
    else $error("dm over voltage not flagged");
  a_lines_released_idle: assert property (!detect_busy && !$past(detect_busy) |-> line_ctl == LINES_OFF)
    else $error("line sources left on");
  a_gate_off_busy: assert property ($past(detect_busy) |-> load_switch_gate_n)
    else $error("load switch on during detection");
  a_suspend_busy: assert property ($past(detect_busy) |-> suspend && input_limit == LIM_SUSPEND)
    else $error("input current drawn during detection");
endmodule : ucpc_checker

// *** dv/ucpc_port_model.sv ***
`timescale 1ns/1ps
// far side: host port, charger or divided supply as comparator levels
module ucpc_port_model
  import ucpc_pkg::*;
(
  input  wire logic       supply_on,
  input  wire logic       pin_hi,
  input  wire logic [3:0] kind,
  input  wire ucpc_line_t line_ctl,
  output ucpc_comp_t      comp
);
  // kind: 0 sdp 1 cdp 2 dcp 3 dp hot 4..6 divided 7 dm hot 8 open lines
  always_comb begin
    comp = '0;
    comp.supply_ok = supply_on;
    comp.limit_pin = pin_hi;
    comp.dp_ovp = kind == 4'h3;
    comp.dm_ovp = kind == 4'h7;
    comp.dp_div_mid = kind == 4'h4 || kind == 4'h5;
    comp.dp_div_high = kind == 4'h6;
    comp.dm_div_mid = kind == 4'h4 || kind == 4'h6;
    comp.dm_div_high = kind == 4'h5;
    // open lines float high under the contact source; dcp shorts dm onto dp
    comp.dp_dat = line_ctl.dcd_src_en ? kind == 4'h8 : line_ctl.dp_src_en || (line_ctl.dm_src_en && kind == 4'h2);
    comp.dm_dat = line_ctl.dp_src_en && (kind == 4'h1 || kind == 4'h2);
  end
endmodule : ucpc_port_model

// *** inc/ucpc_pkg.sv ***
package ucpc_pkg;
  // clock rate and detection timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SETTLE_MS       = 40;   // line settle before a comparator is judged
  localparam int unsigned DCD_TIMEOUT_MS  = 600;  // contact detection give-up time
  localparam int unsigned SETTLE_CYC      = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned DCD_TIMEOUT_CYC = DCD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W           = 25;

  // result register
  localparam logic [7:0] RESULT_OFFSET = 8'h04;
  localparam int unsigned CLASS_LSB    = 3;
  localparam int unsigned CLASS_MSB    = 5;
  localparam logic [7:0] RESULT_RESET  = 8'h00;

  typedef enum logic [2:0] {
    CLS_SDP    = 3'b000,
    CLS_CDP    = 3'b001,
    CLS_DCP    = 3'b010,
    CLS_DP_ERR = 3'b011,
    CLS_DIV1   = 3'b100,
    CLS_DIV2   = 3'b101,
    CLS_DIV3   = 3'b110,
    CLS_DM_ERR = 3'b111
  } ucpc_class_t;

  // input current limit selection
  typedef enum logic [2:0] {
    LIM_SUSPEND = 3'b000,
    LIM_100MA   = 3'b001,
    LIM_500MA   = 3'b010,
    LIM_1000MA  = 3'b011,
    LIM_1500MA  = 3'b100,
    LIM_1800MA  = 3'b101
  } ucpc_limit_t;

  // analog comparator indications from the supply, dp and dm lines, plus the sdp limit select pin
  typedef struct packed {
    logic supply_ok;   // supply above undervoltage threshold
    logic dp_ovp;      // dp above 3.3 v
    logic dm_ovp;      // dm above 3.3 v
    logic dp_dat;      // dp above data detection reference
    logic dm_dat;      // dm above data detection reference
    logic dp_div_mid;  // dp in the 2.00 v band
    logic dp_div_high; // dp in the 2.68 v band
    logic dm_div_mid;
    logic dm_div_high;
    logic limit_pin;   // sdp limit select pin
  } ucpc_comp_t;
  localparam int unsigned COMP_W = $bits(ucpc_comp_t);

  // line source and sink enables
  typedef struct packed {
    logic dcd_src_en;  // contact detection current source on dp
    logic dp_src_en;
    logic dm_src_en;
    logic dp_sink_en;
    logic dm_sink_en;
  } ucpc_line_t;
  localparam ucpc_line_t LINES_OFF = '0;
endpackage : ucpc_pkg
